// [qtm_defs.vh]
`ifndef QTM_DEFS_VH
`define QTM_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define QTM_IDX_CMP0 16'hffd0
`define QTM_IDX_CMP1 16'hffd1
`define QTM_IDX_CMP2 16'hffd2
`define QTM_IDX_CMP3 16'hffd3
`define QTM_IDX_CLK_SEL 16'hffd8
`define QTM_IDX_FLOP_CTRL 16'hffd9
`define QTM_IDX_PAIR_MODE 16'hffda
`define QTM_IDX_RUN 16'hffdb
`define QTM_IDX_STATUS 16'hffdc
`define QTM_IDX_COUNTS 16'hffdd

// Reset values.
`define QTM_RST_CLK_SEL 8'h00
`define QTM_RST_PAIR_MODE 8'h00
`define QTM_RST_RUN 8'h00
`define QTM_RST_CMP 8'h00
`define QTM_RST_TOGGLE 2'h0

// Field positions.
`define QTM_RUN_PRESCALER_BIT 5
`define QTM_LO_MODE_MSB 3
`define QTM_LO_MODE_LSB 2
`define QTM_HI_MODE_MSB 7
`define QTM_HI_MODE_LSB 6
`define QTM_LO_PWM_MSB 1
`define QTM_LO_PWM_LSB 0
`define QTM_HI_PWM_MSB 5
`define QTM_HI_PWM_LSB 4
`define QTM_LO_SRC_BIT 0
`define QTM_LO_EN_BIT 1
`define QTM_LO_SOFT_MSB 3
`define QTM_LO_SOFT_LSB 2
`define QTM_HI_SRC_BIT 4
`define QTM_HI_EN_BIT 5
`define QTM_HI_SOFT_MSB 7
`define QTM_HI_SOFT_LSB 6

// Pair modes.
`define QTM_MODE_DUAL8 2'h0
`define QTM_MODE_CASC16 2'h1
`define QTM_MODE_PULSE 2'h2
`define QTM_MODE_PWM 2'h3

// Clock select codes.
`define QTM_CSEL_MATCH 2'h0
`define QTM_CSEL_FAST 2'h1
`define QTM_CSEL_MID 2'h2
`define QTM_CSEL_SLOW 2'h3

// Software flop commands.
`define QTM_SOFT_CLEAR 2'h0
`define QTM_SOFT_SET 2'h1
`define QTM_SOFT_INVERT 2'h2
`define QTM_SOFT_NONE 2'h3

// PWM periods in counts.
`define QTM_PWM_P6 8'h3f
`define QTM_PWM_P7 8'h7f
`define QTM_PWM_P8 8'hff

// Timing: source clocks per prescaler step, and the tap periods in source clocks.
`define QTM_SRC_PER_STEP 4
`define QTM_TAP_FAST_SRC 8
`define QTM_TAP_MID_SRC 128
`define QTM_TAP_SLOW_SRC 2048

`endif

// [qtm_timer.v]
`timescale 1ns/10ps
`include "qtm_defs.vh"

// One 8-bit up-counter with its comparator; the compare value comes in on cmp from the top level.
module qtm_timer (
	input wire pclk,
	input wire presetn,
	input wire ce,
	input wire run,
	input wire tick,
	input wire clr,
	input wire [7:0] cmp,
	output reg [7:0] cnt_q,
	output wire eq,
	output wire hit,
	output wire ovf
);
	wire [7:0] nxt;

	// A compare value of zero matches when the counter wraps from ff to 00.
	assign nxt = tick ? cnt_q + 8'h01 : cnt_q;
	assign eq = (nxt == cmp);
	assign hit = run & tick & eq;
	assign ovf = run & tick & (cnt_q == 8'hff); // A stopped timer must not carry into its partner either.

	// Stopped counters are held at zero; a clear beats the increment.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'h00;
		end else if (ce) begin
			if (!run || clr) begin
				cnt_q <= 8'h00;
			end else if (tick) begin
				cnt_q <= nxt;
			end
		end
	end
endmodule

// [qtm_top.v]
`timescale 1ns/10ps
`include "qtm_defs.vh"

// Summary of operation
// - A 9-bit prescaler steps at a quarter of the source clock, shared by all timers.
// - Prescaler taps pulse every 8, 128 and 2048 source clocks.
// - Run register bit five lets the prescaler count; zero holds it cleared; reset zero.
// - Each of four timers has an 8-bit up-counter stepping on its chosen clock.
// - First timer of a pair: select 01, 10, 11 picks fast, middle, slow tap.
// - Cascaded mode: second timer counts first timer overflows, ignoring its select.
// - Otherwise second timer select 00 takes first match, 01..11 the three taps.
// - Pair mode field: dual 8-bit, cascaded 16-bit, pulse, PWM; reset gives dual.
// - PWM cycle field sets 63, 127 or 255 counts, only in PWM mode.
// - Run register counts, stops or clears each counter; reset clears and stops all.
// - One output flop per timer pair, two in all, under flop control register.
// - Toggle source: in dual mode 0 first timer, 1 second timer; else keep 1.
// - Toggle enable lets a match invert the pair flop when one.
// - Write-only soft field: 00 clear, 01 set, 10 invert, 11 none; reads 11.
// - Upper pair flop uses upper nibble: source bit 4, enable 5, soft 7:6.
// - A match clears the counter, pulses the interrupt and may invert the flop.
// - Compare value zero matches on counter overflow rather than at zero.
// - Cascaded: low byte first disarms compare until high byte; both must match.

module qtm_top #(
	parameter ADDR_W = 18
) (
	input wire pclk,
	input wire presetn,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_q,
	output reg pready_q,
	output reg pslverr_q,
	output reg lower_pair_output_flop,
	output reg upper_pair_output_flop,
	output reg [3:0] timer_match_interrupt
);
	// Worked out as integers first, then cut to the divider widths on purpose.
	localparam integer STEP_LAST_I = `QTM_SRC_PER_STEP - 1;
	localparam integer FAST_MASK_I = (`QTM_TAP_FAST_SRC / `QTM_SRC_PER_STEP) - 1;
	localparam integer MID_MASK_I = (`QTM_TAP_MID_SRC / `QTM_SRC_PER_STEP) - 1;
	localparam integer SLOW_MASK_I = (`QTM_TAP_SLOW_SRC / `QTM_SRC_PER_STEP) - 1;
	localparam [1:0] STEP_LAST = STEP_LAST_I[1:0];
	localparam [8:0] FAST_MASK = FAST_MASK_I[8:0];
	localparam [8:0] MID_MASK = MID_MASK_I[8:0];
	localparam [8:0] SLOW_MASK = SLOW_MASK_I[8:0];

	reg [7:0] timer_clock_select;
	reg [7:0] timer_pair_mode;
	reg [7:0] timer_run_register;
	reg [1:0] lower_toggle_ctl;
	reg [1:0] upper_toggle_ctl;
	reg [7:0] cmp_q [0:3];
	reg [1:0] armed_q;
	reg [1:0] step_q;
	reg [8:0] pre_q;

	wire access;
	wire wr_now;
	wire [15:0] idx;
	wire prescaler_run_bit;
	wire step;
	wire tap_fast;
	wire tap_mid;
	wire tap_slow;
	wire [1:0] lower_pair_mode_field;
	wire [1:0] upper_pair_mode_field;
	wire [1:0] lower_pwm_cycle_field;
	wire [1:0] upper_pwm_cycle_field;
	wire [7:0] cnt [0:3];
	wire [3:0] eq;
	wire [3:0] hit;
	wire [3:0] ovf;
	wire [3:0] tick;
	wire [3:0] clr;
	wire [3:0] match;
	wire [1:0] pair_match;
	wire [1:0] toggle;

	// Pick a prescaler tap from a select code; code 00 means no tap.
	function tap_pick;
		input [1:0] sel;
		input fast;
		input mid;
		input slow;
		begin
			case (sel)
				`QTM_CSEL_FAST: tap_pick = fast;
				`QTM_CSEL_MID: tap_pick = mid;
				`QTM_CSEL_SLOW: tap_pick = slow;
				default: tap_pick = 1'b0;
			endcase
		end
	endfunction

	// PWM period in counts for a cycle field; 00 leaves the full range.
	function [7:0] pwm_period;
		input [1:0] fld;
		begin
			case (fld)
				2'h1: pwm_period = `QTM_PWM_P6;
				2'h2: pwm_period = `QTM_PWM_P7;
				default: pwm_period = `QTM_PWM_P8;
			endcase
		end
	endfunction

	// Apply a software command to the current flop value.
	function soft_apply;
		input [1:0] cmd;
		input cur;
		begin
			case (cmd)
				`QTM_SOFT_CLEAR: soft_apply = 1'b0;
				`QTM_SOFT_SET: soft_apply = 1'b1;
				`QTM_SOFT_INVERT: soft_apply = ~cur;
				default: soft_apply = cur;
			endcase
		end
	endfunction

	// A write lands on the edge where the access phase sees pready high.
	assign access = psel & penable;
	assign wr_now = access & pready_q & pwrite;
	assign idx = paddr[17:2];

	assign prescaler_run_bit = timer_run_register[`QTM_RUN_PRESCALER_BIT];
	assign lower_pair_mode_field = timer_pair_mode[`QTM_LO_MODE_MSB:`QTM_LO_MODE_LSB];
	assign upper_pair_mode_field = timer_pair_mode[`QTM_HI_MODE_MSB:`QTM_HI_MODE_LSB];
	assign lower_pwm_cycle_field = timer_pair_mode[`QTM_LO_PWM_MSB:`QTM_LO_PWM_LSB];
	assign upper_pwm_cycle_field = timer_pair_mode[`QTM_HI_PWM_MSB:`QTM_HI_PWM_LSB];

	// Quarter-rate step divider; pclk stands in for the source clock.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_q <= 2'h0;
		end else if (ce) begin
			if (!prescaler_run_bit) begin
				step_q <= 2'h0;
			end else begin
				step_q <= step_q + 2'h1;
			end
		end
	end
	assign step = prescaler_run_bit & (step_q == STEP_LAST);

	// The prescaler is held at zero while stopped, so taps restart in phase.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 9'h000;
		end else if (ce) begin
			if (!prescaler_run_bit) begin
				pre_q <= 9'h000;
			end else if (step) begin
				pre_q <= pre_q + 9'h001;
			end
		end
	end

	// Each tap fires once per full cycle of its low prescaler bits.
	assign tap_fast = step & ((pre_q & FAST_MASK) == FAST_MASK);
	assign tap_mid = step & ((pre_q & MID_MASK) == MID_MASK);
	assign tap_slow = step & ((pre_q & SLOW_MASK) == SLOW_MASK);

	// Counter clocks; in cascaded mode the second timer takes first-timer overflows and its select is ignored.
	assign tick[0] = tap_pick(timer_clock_select[1:0], tap_fast, tap_mid, tap_slow);
	assign tick[2] = tap_pick(timer_clock_select[5:4], tap_fast, tap_mid, tap_slow);
	assign tick[1] = (lower_pair_mode_field == `QTM_MODE_CASC16) ? ovf[0] :
		(timer_clock_select[3:2] == `QTM_CSEL_MATCH) ? match[0] :
		tap_pick(timer_clock_select[3:2], tap_fast, tap_mid, tap_slow);
	assign tick[3] = (upper_pair_mode_field == `QTM_MODE_CASC16) ? ovf[2] :
		(timer_clock_select[7:6] == `QTM_CSEL_MATCH) ? match[2] :
		tap_pick(timer_clock_select[7:6], tap_fast, tap_mid, tap_slow);

	// Pair-level match logic, shared by both pairs through a generate loop.
	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : g_pair
			wire [1:0] mode;
			wire [1:0] pwm;
			wire casc;
			wire pwm_wrap;
			assign mode = (p == 0) ? lower_pair_mode_field : upper_pair_mode_field;
			assign pwm = (p == 0) ? lower_pwm_cycle_field : upper_pwm_cycle_field;
			assign casc = (mode == `QTM_MODE_CASC16);
			// In PWM mode the second counter wraps at the chosen period.
			assign pwm_wrap = (mode == `QTM_MODE_PWM) & tick[2*p+1] & (cnt[2*p+1] == pwm_period(pwm));
			// Cascaded match needs both halves equal and the compare re-armed.
			assign pair_match[p] = casc & armed_q[p] & hit[2*p] & eq[2*p+1];
			assign match[2*p] = ~casc & hit[2*p];
			assign match[2*p+1] = casc ? pair_match[p] : hit[2*p+1];
			assign clr[2*p] = casc ? pair_match[p] : hit[2*p];
			assign clr[2*p+1] = casc ? pair_match[p] : (hit[2*p+1] | pwm_wrap);
		end
	endgenerate

	// Four identical timers; the run register bits 0 to 3 gate each one.
	genvar t;
	generate
		for (t = 0; t < 4; t = t + 1) begin : g_tmr
			qtm_timer u_timer (
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.run(timer_run_register[t]),
				.tick(tick[t]),
				.clr(clr[t]),
				.cmp(cmp_q[t]),
				.cnt_q(cnt[t]),
				.eq(eq[t]),
				.hit(hit[t]),
				.ovf(ovf[t])
			);
		end
	endgenerate

	// Hardware toggle selection: dual mode honours the source bit, other modes use the second timer.
	assign toggle[0] = lower_toggle_ctl[1] & ((lower_pair_mode_field != `QTM_MODE_DUAL8 || lower_toggle_ctl[0]) ?
		match[1] : match[0]);
	assign toggle[1] = upper_toggle_ctl[1] & ((upper_pair_mode_field != `QTM_MODE_DUAL8 || upper_toggle_ctl[0]) ?
		match[3] : match[2]);

	// Register writes; the compare arming flag is set by high byte, cleared by low byte.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_clock_select <= `QTM_RST_CLK_SEL;
			timer_pair_mode <= `QTM_RST_PAIR_MODE;
			timer_run_register <= `QTM_RST_RUN;
			lower_toggle_ctl <= `QTM_RST_TOGGLE;
			upper_toggle_ctl <= `QTM_RST_TOGGLE;
			cmp_q[0] <= `QTM_RST_CMP;
			cmp_q[1] <= `QTM_RST_CMP;
			cmp_q[2] <= `QTM_RST_CMP;
			cmp_q[3] <= `QTM_RST_CMP;
			armed_q <= 2'h3;
		end else if (ce && wr_now) begin
			case (idx)
				`QTM_IDX_CLK_SEL: timer_clock_select <= pwdata[7:0];
				`QTM_IDX_PAIR_MODE: timer_pair_mode <= pwdata[7:0];
				`QTM_IDX_RUN: timer_run_register <= {2'h0, pwdata[5], 1'b0, pwdata[3:0]};
				`QTM_IDX_FLOP_CTRL: begin
					lower_toggle_ctl <= pwdata[`QTM_LO_EN_BIT:`QTM_LO_SRC_BIT];
					upper_toggle_ctl <= pwdata[`QTM_HI_EN_BIT:`QTM_HI_SRC_BIT];
				end
				`QTM_IDX_CMP0: begin
					cmp_q[0] <= pwdata[7:0];
					armed_q[0] <= 1'b0;
				end
				`QTM_IDX_CMP1: begin
					cmp_q[1] <= pwdata[7:0];
					armed_q[0] <= 1'b1;
				end
				`QTM_IDX_CMP2: begin
					cmp_q[2] <= pwdata[7:0];
					armed_q[1] <= 1'b0;
				end
				`QTM_IDX_CMP3: begin
					cmp_q[3] <= pwdata[7:0];
					armed_q[1] <= 1'b1;
				end
				default: armed_q <= armed_q;
			endcase
		end
	end

	// Output flops; a software command on the same edge acts on the hardware-toggled value, so only clear and set override it.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lower_pair_output_flop <= 1'b0;
			upper_pair_output_flop <= 1'b0;
		end else if (ce) begin
			if (wr_now && idx == `QTM_IDX_FLOP_CTRL) begin
				lower_pair_output_flop <= soft_apply(pwdata[`QTM_LO_SOFT_MSB:`QTM_LO_SOFT_LSB],
					lower_pair_output_flop ^ toggle[0]);
				upper_pair_output_flop <= soft_apply(pwdata[`QTM_HI_SOFT_MSB:`QTM_HI_SOFT_LSB],
					upper_pair_output_flop ^ toggle[1]);
			end else begin
				lower_pair_output_flop <= lower_pair_output_flop ^ toggle[0];
				upper_pair_output_flop <= upper_pair_output_flop ^ toggle[1];
			end
		end
	end

	// Match interrupt pulses, one cycle each, registered so they leave from a flop.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_match_interrupt <= 4'h0;
		end else if (ce) begin
			timer_match_interrupt <= match;
		end
	end

	// Bus answer: one wait state so read data and pready both come from flops.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else if (ce) begin
			pready_q <= access & ~pready_q;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
			if (access && !pready_q) begin
				case (idx)
					`QTM_IDX_CLK_SEL: prdata_q <= {24'h000000, timer_clock_select};
					`QTM_IDX_PAIR_MODE: prdata_q <= {24'h000000, timer_pair_mode};
					`QTM_IDX_RUN: prdata_q <= {24'h000000, timer_run_register};
					`QTM_IDX_FLOP_CTRL: prdata_q <= {24'h000000, `QTM_SOFT_NONE, upper_toggle_ctl,
						`QTM_SOFT_NONE, lower_toggle_ctl};
					`QTM_IDX_CMP0: prdata_q <= {24'h000000, cmp_q[0]};
					`QTM_IDX_CMP1: prdata_q <= {24'h000000, cmp_q[1]};
					`QTM_IDX_CMP2: prdata_q <= {24'h000000, cmp_q[2]};
					`QTM_IDX_CMP3: prdata_q <= {24'h000000, cmp_q[3]};
					`QTM_IDX_STATUS: prdata_q <= {28'h0000000, armed_q, upper_pair_output_flop,
						lower_pair_output_flop};
					`QTM_IDX_COUNTS: prdata_q <= {cnt[3], cnt[2], cnt[1], cnt[0]};
					default: pslverr_q <= 1'b1;
				endcase
			end
		end
	end
endmodule

// [qtm_top_asserts.sv]
`timescale 1ns/10ps
`include "qtm_defs.vh"

// Watches the ports only; register state is rebuilt from bus writes seen at the pins.
module qtm_top_asserts #(
	parameter ADDR_W = 18
) (
	input wire pclk,
	input wire presetn,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata_q,
	input wire pready_q,
	input wire pslverr_q,
	input wire lower_pair_output_flop,
	input wire upper_pair_output_flop,
	input wire [3:0] timer_match_interrupt
);
	wire wl;
	wire wfc;
	wire [7:0] live;
	reg [7:0] run_q;
	reg [7:0] r1_q;
	reg [7:0] r2_q;
	reg [7:0] r3_q;
	reg [7:0] mode_q;
	reg [7:0] fc_q;
	reg [2:0] casc_q;

	// A write lands on the edge that samples the answer; ce is part of it.
	assign wl = ce && psel && penable && pwrite && pready_q && !pslverr_q;
	assign wfc = wl && paddr[ADDR_W-1:2] == `QTM_IDX_FLOP_CTRL;
	// Run history is kept four deep because a match already in flight may still pulse.
	assign live = run_q | r1_q | r2_q | r3_q;

	// Shadow registers, cleared by reset like the real ones.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 8'h00;
			r1_q <= 8'h00;
			r2_q <= 8'h00;
			r3_q <= 8'h00;
			mode_q <= 8'h00;
			fc_q <= 8'h00;
			casc_q <= 3'h0;
		end else begin
			r1_q <= run_q;
			r2_q <= r1_q;
			r3_q <= r2_q;
			casc_q <= {casc_q[1:0], mode_q[3:2] == 2'b01};
			if (wl && paddr[ADDR_W-1:2] == `QTM_IDX_RUN)
				run_q <= pwdata[7:0];
			if (wl && paddr[ADDR_W-1:2] == `QTM_IDX_PAIR_MODE)
				mode_q <= pwdata[7:0];
			if (wfc)
				fc_q <= pwdata[7:0];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_stop_quiet: assert property ((timer_match_interrupt & ~(live[3:0] & {4{live[5]}})) == 4'h0)
		else $error("match pulse while counting is stopped");
	chk_irq_single: assert property (|timer_match_interrupt |=> (timer_match_interrupt & $past(timer_match_interrupt)) == 4'h0)
		else $error("match pulse longer than one cycle");
	chk_soft_clear_lo: assert property (wfc && pwdata[3:2] == 2'b00 |=> !lower_pair_output_flop)
		else $error("lower flop not cleared by software");
	chk_soft_set_hi: assert property (wfc && pwdata[7:6] == 2'b01 |=> upper_pair_output_flop)
		else $error("upper flop not set by software");
	chk_lo_hold: assert property (!fc_q[1] && !wfc |=> $stable(lower_pair_output_flop))
		else $error("lower flop moved with toggling disabled");
	chk_hi_hold: assert property (!fc_q[5] && !wfc |=> $stable(upper_pair_output_flop))
		else $error("upper flop moved with toggling disabled");
	chk_hw_toggle_lo: assert property (timer_match_interrupt[0] && fc_q[1:0] == 2'b10 && mode_q[3:2] == 2'b00
		&& !$past(wl) && !$past(wl, 2) |-> lower_pair_output_flop != $past(lower_pair_output_flop, 2))
		else $error("lower flop did not follow first timer match");
	chk_casc_low_quiet: assert property (&casc_q |-> !timer_match_interrupt[0])
		else $error("first timer pulsed in cascaded mode");

	cover property (timer_match_interrupt[1] && casc_q[0]);
	cover property (wfc && pwdata[3:2] == 2'b10);
	cover property (pslverr_q && pready_q);
endmodule

// [qtm_top_tb.sv]
`timescale 1ns/10ps
`include "qtm_defs.vh"

module qtm_top_tb;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg ce = 1'b1;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [17:0] paddr = 18'h00000;
	reg [31:0] pwdata = 32'h00000000;
	wire [31:0] prdata_q;
	wire pready_q;
	wire pslverr_q;
	wire lo_ff;
	wire hi_ff;
	wire [3:0] irq;
	integer fail_count = 0;
	integer n_compared = 0;
	integer i;
	integer n;
	integer lo_t;
	integer hi_t;
	integer q0;
	reg [31:0] rd;
	reg err;
	reg [1:0] c;
	reg e;

	qtm_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
		.lower_pair_output_flop(lo_ff), .upper_pair_output_flop(hi_ff), .timer_match_interrupt(irq));

	// Half period of 20 ns gives the 40 ns bus clock.
	always #20 pclk = ~pclk;

	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	// One bus transfer; the request is held until pready is sampled high, then one idle edge.
	task apb(input wr, input [15:0] idx, input [7:0] wd);
		integer k;
		begin
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= {idx, 2'b00};
			pwdata <= {24'h000000, wd};
			@(posedge pclk);
			penable <= 1'b1;
			k = 0;
			@(posedge pclk);
			while (pready_q !== 1'b1 && k < 20) begin
				@(posedge pclk);
				k = k + 1;
			end
			if (k >= 20) begin
				fail_count = fail_count + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, pready_q, 1'b1);
			end
			rd = prdata_q;
			err = pslverr_q;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask

	task rdc(input [15:0] idx, input [7:0] exp);
		begin
			apb(1'b0, idx, 8'h00);
			chk(rd, {24'h000000, exp});
		end
	endtask

	// Cycles from one pulse on the chosen bit to the next; the cap turns a dead timer into a mismatch.
	task per(input [1:0] b);
		begin
			n = 0;
			while (irq[b] !== 1'b1 && n < 5000) begin
				@(posedge pclk);
				n = n + 1;
			end
			n = 0;
			@(posedge pclk);
			n = 1;
			while (irq[b] !== 1'b1 && n < 5000) begin
				@(posedge pclk);
				n = n + 1;
			end
		end
	endtask

	// Counts flop changes and first-timer pulses over a fixed window.
	task win(input integer len);
		reg lp;
		reg hp;
		begin
			lo_t = 0;
			hi_t = 0;
			q0 = 0;
			lp = lo_ff;
			hp = hi_ff;
			repeat (len) begin
				@(posedge pclk);
				lo_t = lo_t + (lo_ff !== lp);
				hi_t = hi_t + (hi_ff !== hp);
				q0 = q0 + (irq[0] === 1'b1);
				lp = lo_ff;
				hp = hi_ff;
			end
		end
	endtask

	task tally_and_finish;
		begin
			$display("compared %0d, mismatches %0d", n_compared, fail_count);
			if (fail_count == 0 && n_compared > 0) begin
				$display("Result: passed");
			end else begin
				$display("Result: failed");
			end
			$finish;
		end
	endtask

	// The longest test waits a few slow-tap periods, so this bound is generous but finite.
	initial begin
		repeat (60000) @(posedge pclk);
		fail_count = fail_count + 1;
		tally_and_finish;
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(`QTM_IDX_CLK_SEL, 8'h00);
		rdc(`QTM_IDX_PAIR_MODE, 8'h00);
		rdc(`QTM_IDX_RUN, 8'h00);
		rdc(`QTM_IDX_FLOP_CTRL, 8'hcc);
		apb(1'b1, `QTM_IDX_FLOP_CTRL, 8'h13);
		rdc(`QTM_IDX_FLOP_CTRL, 8'hdf);
		apb(1'b1, `QTM_IDX_RUN, 8'hff);
		rdc(`QTM_IDX_RUN, 8'h2f);
		apb(1'b0, 16'hffd4, 8'h00);
		chk({err, rd[30:0]}, 32'h80000000);
		$display("test registers done");
		apb(1'b1, `QTM_IDX_RUN, 8'h20);
		apb(1'b1, `QTM_IDX_CMP0, 8'h01);
		apb(1'b1, `QTM_IDX_CMP2, 8'h01);
		for (i = 1; i < 4; i = i + 1) begin
			apb(1'b1, `QTM_IDX_CLK_SEL, {2'b00, i[1:0], 2'b00, i[1:0]});
			apb(1'b1, `QTM_IDX_RUN, 8'h25);
			per(2'd0);
			chk(n, 8 << (4 * (i - 1)));
			per(2'd2);
			chk(n, 8 << (4 * (i - 1)));
			apb(1'b1, `QTM_IDX_RUN, 8'h20);
		end
		apb(1'b1, `QTM_IDX_CMP0, 8'h02);
		apb(1'b1, `QTM_IDX_CMP1, 8'h01);
		for (i = 0; i < 4; i = i + 1) begin
			apb(1'b1, `QTM_IDX_CLK_SEL, {4'h0, i[1:0], 2'b01});
			apb(1'b1, `QTM_IDX_RUN, 8'h23);
			per(2'd1);
			chk(n, (i == 0) ? 16 : (8 << (4 * (i - 1))));
			apb(1'b1, `QTM_IDX_RUN, 8'h20);
		end
		apb(1'b1, `QTM_IDX_CMP0, 8'h00);
		apb(1'b1, `QTM_IDX_CLK_SEL, 8'h01);
		apb(1'b1, `QTM_IDX_RUN, 8'h21);
		per(2'd0);
		chk(n, 2048);
		$display("test clock sources done");
		// Second timer select is set to the slow tap to show it is ignored when cascaded.
		apb(1'b1, `QTM_IDX_RUN, 8'h20);
		apb(1'b1, `QTM_IDX_PAIR_MODE, 8'h04);
		apb(1'b1, `QTM_IDX_CLK_SEL, 8'h0d);
		apb(1'b1, `QTM_IDX_CMP0, 8'h02);
		apb(1'b1, `QTM_IDX_CMP1, 8'h01);
		apb(1'b1, `QTM_IDX_RUN, 8'h23);
		per(2'd1);
		chk(n, 2064);
		win(2100);
		chk(q0, 0);
		$display("test cascade done");
		apb(1'b1, `QTM_IDX_RUN, 8'h20);
		apb(1'b1, `QTM_IDX_PAIR_MODE, 8'h00);
		for (i = 0; i < 5; i = i + 1) begin
			c = 10'b10_00_10_11_01 >> (2 * i);
			e = (c == 2'b00) ? 1'b0 : (c == 2'b01) ? 1'b1 : (c == 2'b10) ? ~e : e;
			apb(1'b1, `QTM_IDX_FLOP_CTRL, {c, 2'b00, c, 2'b00});
			chk({hi_ff, lo_ff}, {e, e});
		end
		$display("test software flop done");
		apb(1'b1, `QTM_IDX_CLK_SEL, 8'h41);
		apb(1'b1, `QTM_IDX_CMP0, 8'h01);
		apb(1'b1, `QTM_IDX_CMP3, 8'h01);
		apb(1'b1, `QTM_IDX_FLOP_CTRL, 8'hfe);
		apb(1'b1, `QTM_IDX_RUN, 8'h29);
		win(80);
		chk({lo_t[15:0], hi_t[15:0]}, 32'h000a000a);
		apb(1'b1, `QTM_IDX_FLOP_CTRL, 8'hdf);
		win(80);
		chk({lo_t[15:0], hi_t[15:0]}, 32'h00000000);
		apb(1'b1, `QTM_IDX_RUN, 8'h0f);
		win(300);
		chk(q0, 0);
		$display("test hardware flop and stop done");
		// The prescaler restarts from zero, so the fast tap lands every 8 cycles after the run write.
		apb(1'b1, `QTM_IDX_RUN, 8'h00);
		apb(1'b1, `QTM_IDX_PAIR_MODE, 8'h0d);
		apb(1'b1, `QTM_IDX_CLK_SEL, 8'h01);
		apb(1'b1, `QTM_IDX_CMP1, 8'h00);
		apb(1'b1, `QTM_IDX_RUN, 8'h23);
		repeat (560) @(posedge pclk);
		// Seventy ticks against a 64-tick cycle (wrap after count 63) leave the second counter at 6 after one wrap.
		apb(1'b1, `QTM_IDX_RUN, 8'h03);
		apb(1'b0, `QTM_IDX_COUNTS, 8'h00);
		chk(rd, 32'h00000600);
		apb(1'b1, `QTM_IDX_FLOP_CTRL, 8'h04);
		rdc(`QTM_IDX_STATUS, 8'h0d);
		$display("test pwm wrap done");
		tally_and_finish;
	end
endmodule

bind qtm_top qtm_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
	.pslverr_q(pslverr_q), .lower_pair_output_flop(lower_pair_output_flop),
	.upper_pair_output_flop(upper_pair_output_flop), .timer_match_interrupt(timer_match_interrupt));
